// File: test/tb.sv
/*
  Self-checking bench of the video output timing unit.
  Assumes the far-side model of its own file; internal timing first, then received syncs.
*/
module tb
  import vot_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  vot_cfg_t    cfg;
  vot_pix_t    pix, pat_a, pat_b;
  logic        clk, rst_n, pix_valid, feed_on, run, sel;
  logic        pix_ready, pco, pco_oe, hso, hs_oe, vso, vs_oe, active, underrun;
  logic        fpclk, fhs, fvs;
  logic [23:0] bus;
  int          bad_count, checks_done, pushes;
  wire logic   pclk_w = pco_oe ? pco : fpclk;
  wire logic   hs_w   = hs_oe ? hso : fhs;
  wire logic   vs_w   = vs_oe ? vso : fvs;

  always #5 clk = ~clk;

  vot_timing_unit DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg), .i_pix(pix),
    .i_pix_valid(pix_valid), .o_pix_ready(pix_ready), .i_pixel_clock(pclk_w),
    .o_pixel_clock(pco), .o_pixel_clock_oe(pco_oe), .i_hsync_n(hs_w), .o_hsync_n(hso),
    .o_hsync_oe(hs_oe), .i_vsync_n(vs_w), .o_vsync_n(vso), .o_vsync_oe(vs_oe),
    .o_pixel_bus(bus), .o_active(active), .o_underrun(underrun));

  vot_far_model FAR (.i_run(run), .o_pclk(fpclk), .o_hsync_n(fhs), .o_vsync_n(fvs));

  // Pixel source, alternating two patterns
  always @(posedge clk) begin
    pix_valid <= feed_on;
    if (pix_valid && pix_ready) begin
      pushes <= pushes + 1;
      sel    <= ~sel;
      pix    <= sel ? pat_a : pat_b;
    end
  end

  // ========================================
  // Helpers
  task automatic results();
    $display("mismatches %0d comparisons %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_n(input int got, input int exp);
    chk_v(24'(got), 24'(exp));
  endtask : chk_n

  function automatic logic sig(input int w);
    case (w)
      0: return active;
      1: return hs_w;
      2: return pix_ready;
      3: return vso;
      default: return hso;
    endcase
  endfunction : sig

  task automatic wait_for(input int w, input logic lvl, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if (sig(w) === lvl)
        return;
    end
    bad_count++;
    results();
  endtask : wait_for

  task automatic fall(input int w, input int lim);
    wait_for(w, 1'b1, lim);
    wait_for(w, 1'b0, lim);
  endtask : fall

  task automatic hold_len(input int w, input logic lvl, output int n);
    n = 0;
    while (sig(w) === lvl && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask : hold_len

  task automatic toggles(output int n);
    logic last;
    n = 0;
    last = vso;
    repeat (5148) begin
      @(negedge clk);
      if (vso !== last)
        n++;
      last = vso;
    end
  endtask : toggles

  // ========================================
  // Scenarios
  task automatic t_reset();
    @(negedge clk);
    chk_v(bus, 24'h000000);
    chk_v({22'h0, hso, vso}, 24'h000003);
    chk_v({21'h0, pco, underrun, pix_ready}, 24'h000001);
  endtask : t_reset

  task automatic t_internal();
    int n;
    chk_v({21'h0, hs_oe, vs_oe, pco_oe}, 24'h000007);
    @(negedge clk);
    n = 0;
    repeat (30) begin
      @(negedge clk);
      n += (pco === 1'b1);
    end
    chk_n(n, 20);
    fall(4, 3000);
    hold_len(4, 1'b0, n);
    chk_n(n, 192);
    hold_len(4, 1'b1, n);
    chk_n(n, 2382);
    toggles(n);
    chk_n(n <= 2, 1);
    @(posedge clk) cfg.csync_en <= 1'b1;
    toggles(n);
    chk_n(n >= 4, 1);
  endtask : t_internal

  task automatic t_width(input logic win, input int exp);
    int p0;
    wait_for(0, 1'b0, 5000);
    @(posedge clk) cfg.window <= win;
    fall(1, 5000);
    p0 = pushes;
    fall(1, 5000);
    chk_n(pushes - p0, exp);
  endtask : t_width

  task automatic t_phase();
    int gap, mingap, chg;
    logic [23:0] last;
    @(posedge clk) pat_b <= 24'h5A5A5A;
    wait_for(0, 1'b0, 5000);
    wait_for(0, 1'b1, 5000);
    repeat (20) @(negedge clk);
    last = bus;
    gap = 0;
    mingap = 99;
    chg = 0;
    repeat (200) begin
      @(negedge clk);
      gap++;
      if (bus !== last) begin
        if (chg > 0 && gap < mingap)
          mingap = gap;
        chg++;
        gap = 0;
        last = bus;
      end
    end
    chk_n(mingap >= 4 && chg > 30, 1);
  endtask : t_phase

  task automatic t_fmt(input vot_fmt_t f, input logic lim, input logic [23:0] p, input logic [23:0] exp);
    wait_for(0, 1'b0, 5000);
    @(posedge clk) begin
      cfg.fmt     <= f;
      cfg.limited <= lim;
      pat_a       <= p;
      pat_b       <= p;
    end
    wait_for(0, 1'b1, 5000);
    repeat (100) @(negedge clk);
    chk_v(bus, exp);
  endtask : t_fmt

  task automatic t_yc8();
    logic [23:0] exp [4] = '{24'h006200, 24'h005100, 24'h007300, 24'h005100};
    logic [23:0] last;
    int k;
    t_fmt(FMT_YC8, 1'b0, 24'h736251, 24'h007300);
    k = 0;
    last = bus;
    for (int i = 0; i < 400 && k < 8; i++) begin
      @(negedge clk);
      if (bus !== last && (k > 0 || bus === 24'h006200)) begin
        chk_v(bus, exp[k % 4]);
        k++;
      end
      last = bus;
    end
    chk_n(k, 8);
  endtask : t_yc8

  // ========================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    feed_on = 1'b0;
    run = 1'b0;
    pix_valid = 1'b0;
    sel = 1'b0;
    pix = '0;
    pat_a = 24'h123456;
    pat_b = 24'h123456;
    cfg = '{fmt: FMT_RGB24, sync_out: 1'b1, clk_out: 1'b1, default: 1'b0};
    t_reset();
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_internal();
    @(posedge clk) rst_n <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) begin
        cfg.sync_out <= k[0];
        cfg.clk_out  <= k[1];
      end
      @(negedge clk);
      chk_v({21'h0, hs_oe, vs_oe, pco_oe}, {21'h0, k[0], k[0], k[1]});
    end
    @(posedge clk) cfg <= '{fmt: FMT_RGB24, window: 1'b1, default: 1'b0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk) run <= 1'b1;
    @(posedge clk) feed_on <= 1'b1;
    wait_for(2, 1'b0, 20);
    chk_n(pushes, 4);
    repeat (5) @(negedge clk);
    chk_n(pushes, 4);
    wait_for(0, 1'b1, 90000);
    t_width(1'b1, 352);
    t_width(1'b0, 384);
    t_phase();
    t_fmt(FMT_RGB24, 1'b0, 24'h123456, 24'h123456);
    t_fmt(FMT_RGB24, 1'b1, 24'hFF0080, 24'hEA107D);
    t_fmt(FMT_RGB15, 1'b0, 24'h884010, 24'h004502);
    t_fmt(FMT_YC16, 1'b0, 24'h404051, 24'h005140);
    t_yc8();
    chk_v({23'h0, underrun}, 24'h000000);
    @(posedge clk) feed_on <= 1'b0;
    wait_for(0, 1'b0, 5000);
    wait_for(0, 1'b1, 5000);
    wait_for(0, 1'b0, 5000);
    chk_v({23'h0, underrun}, 24'h000001);
    results();
  end
endmodule : tb

// File: test/vot_far_model.sv
/*
  Far-side sync generator: a pixel clock of its own, line sync and field sync.
  Assumes the bench muxes these outputs with the unit's drivers by output enable.
*/
module vot_far_model #(
  parameter int LINE = 920,
  parameter int HSW  = 64,
  parameter int VSL  = 3,
  // Lines before VBL are shortened to keep runs brief
  parameter int SHORT = 160,
  parameter int VBL   = 40
) (
  input  wire logic i_run,
  output logic      o_pclk,
  output logic      o_hsync_n,
  output logic      o_vsync_n
);
  timeunit 1ns;
  timeprecision 100ps;

  int h;
  int v;
  int len;

  assign len = (v < VBL) ? SHORT : LINE;

  // ========================================
  // Clock and position
  // clock from far side
  initial o_pclk = 1'b0;
  always #10 o_pclk = i_run & ~o_pclk;

  always @(posedge o_pclk or negedge i_run) begin
    if (!i_run) begin
      h <= 0;
      v <= 0;
    end else begin
      h <= (h == len - 1) ? 0 : h + 1;
      if (h == len - 1)
        v <= v + 1;
    end
  end

  assign o_hsync_n = !(i_run && h < HSW);
  assign o_vsync_n = !(i_run && v < VSL);
endmodule : vot_far_model

// File: verilog/vot_fifo.sv
/*
  Pixel FIFO in front of the output formatter.
  Assumes the reader pops only while valid is high and the writer pushes only while ready is high.
*/
module vot_fifo
  import vot_pkg::*;
#(
  parameter int W = PIX_W,
  parameter int D = FIFO_DEPTH
) (
  input  logic         i_sys_clk,
  input  logic         i_rst_n,
  input  logic [W-1:0] i_wr_data,
  input  logic         i_wr_valid,
  output logic         o_wr_ready,
  output logic [W-1:0] o_rd_data,
  output logic         o_rd_valid,
  input  logic         i_rd_ready
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } vot_fifo_t;

  vot_fifo_t s_ff;
  vot_fifo_t nxt_s;
  logic      push;
  logic      pull;

  always_comb begin
    nxt_s = s_ff;
    push  = i_wr_valid & o_wr_ready;
    pull  = i_rd_ready & o_rd_valid;
    if (push) begin
      nxt_s.mem[s_ff.wp] = i_wr_data;
      nxt_s.wp           = (s_ff.wp == AW'(D - 1)) ? '0 : s_ff.wp + 1'b1;
    end
    if (pull) begin
      nxt_s.rp = (s_ff.rp == AW'(D - 1)) ? '0 : s_ff.rp + 1'b1;
    end
    nxt_s.cnt = s_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pull);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_wr_ready = (s_ff.cnt != (AW + 1)'(D));
  assign o_rd_valid = (s_ff.cnt != '0);
  assign o_rd_data  = s_ff.mem[s_ff.rp];

endmodule : vot_fifo

// File: verilog/vot_pkg.sv
/*
  Shared constants, types and helpers of the video output timing unit.
  Assumes a core clock that runs three times for every two pixel clocks when the unit drives the pixel clock.
*/
package vot_pkg;

  // ==========================================================================
  // Pixel clock division (core clock / 3 * 2)
  // ==========================================================================
  localparam logic [1:0]  PHASE_LAST   = 2'h2;

  // ==========================================================================
  // Line and frame geometry, in pixel clocks and lines
  // ==========================================================================
  localparam logic [10:0] H_TOTAL_NTSC = 11'h6B4;
  localparam logic [10:0] H_TOTAL_PAL  = 11'h6C0;
  localparam logic [10:0] H_MAX        = 11'h7FF;
  localparam logic [10:0] HS_WIDTH     = 11'h080;
  localparam logic [10:0] H_START      = 11'h08C;
  localparam logic [9:0]  V_TOTAL_NTSC = 10'h20D;
  localparam logic [9:0]  V_TOTAL_PAL  = 10'h271;
  localparam logic [9:0]  V_ACT_NTSC   = 10'h1E0;
  localparam logic [9:0]  V_ACT_PAL    = 10'h240;
  localparam logic [9:0]  V_START_NTSC = 10'h02A;
  localparam logic [9:0]  V_START_PAL  = 10'h02C;
  localparam logic [9:0]  V_MAX        = 10'h3FF;
  localparam logic [9:0]  VS_LINES     = 10'h006;
  localparam logic [9:0]  W_SOURCE     = 10'h180;
  localparam logic [9:0]  W_WINDOW     = 10'h160;

  // ==========================================================================
  // Pixel levels and data path
  // ==========================================================================
  localparam logic [7:0]  BLACK_Y      = 8'h10;
  localparam logic [7:0]  BLACK_C      = 8'h80;
  localparam logic [7:0]  RANGE_LO     = 8'h10;
  localparam logic [7:0]  RANGE_HI     = 8'hEB;
  localparam logic [15:0] RANGE_SPAN   = 16'h00DB;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          PIX_W        = 24;
  localparam int          SY_PCLK      = 0;
  localparam int          SY_HS        = 1;
  localparam int          SY_VS        = 2;

  typedef enum logic [1:0] {FMT_RGB24, FMT_RGB15, FMT_YC16, FMT_YC8} vot_fmt_t;

  // RGB: hi=blue, mid=green, lo=red.  Luma/chroma: hi=Cr, mid=Cb, lo=Y.
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] mid;
    logic [7:0] lo;
  } vot_pix_t;

  typedef struct packed {
    vot_fmt_t fmt;
    logic     sync_out;
    logic     clk_out;
    logic     csync_en;
    logic     hinterp;
    logic     window;
    logic     pal;
    logic     limited;
  } vot_cfg_t;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [7:0] vot_avg(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[8:1];
  endfunction : vot_avg

  function automatic logic [7:0] vot_scale(input logic [7:0] x);
    logic [15:0] prod;
    prod = {8'h00, x} * RANGE_SPAN;
    return prod[15:8] + RANGE_LO;
  endfunction : vot_scale

  function automatic logic [4:0] vot_dither(input logic [7:0] x, input logic [2:0] th);
    logic [8:0] sum;
    sum = {1'b0, x} + {6'h00, th};
    return sum[8] ? 5'h1F : sum[7:3];
  endfunction : vot_dither

endpackage : vot_pkg

// File: verilog/vot_sync.sv
/*
  Two-stage synchroniser for the pins that arrive from the far side.
  Assumes nothing of the inputs' timing; only the second stage is read outside.
*/
module vot_sync
  import vot_pkg::*;
#(
  parameter int W = 3
) (
  input  logic         i_sys_clk,
  input  logic         i_rst_n,
  input  logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } vot_sync_t;

  vot_sync_t s_ff;
  vot_sync_t nxt_s;

  always_comb begin
    nxt_s        = s_ff;
    nxt_s.stage1 = i_d;
    nxt_s.stage2 = s_ff.stage1;
  end

  // Idle level of the low-active syncs is high
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_ff <= '1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_q = s_ff.stage2;

endmodule : vot_sync

// File: verilog/vot_timing_unit.sv
/*
  Video output timing unit: pixel clock, line/field sync and pixel bus formatting.
  Assumes configuration is held stable while video runs; pin inputs may be asynchronous.
*/
// Operation
// R1: Pixel bus changes when line sync falls, then every second pixel clock.
// R2: Receiver may capture either or both clocks in which a value holds.
// R3: Sync pair direction and pixel clock direction are chosen independently.
// R4: Line and field sync always share one direction.
// R5: Composite sync replaces field sync on its pin when enabled.
// R6: Driven pixel clock is the core clock divided by three halves.
// R7: In all-input setup the far side supplies clock and both syncs.
// R8: Received pixel clock may be asynchronous to the core clock.
// R9: Four output formats: 24-bit RGB, 15-bit RGB, 16- and 8-bit luma/chroma.
// R10: 15-bit RGB is 24-bit RGB dithered to five bits per component.
// R11: Aspect ratio kept; only horizontal interpolation by two is allowed.
// R12: Lines carry 384 or 768 pixels, or a window of 352 or 704.
// R13: No path from this unit to the host; host reads memory instead.
// R14: Host memory transfers use single accesses, not bursts, outside this unit.
// R15: No vertical interpolation; 480 lines at 30 or 576 lines at 25.
// R16: 24-bit RGB puts blue high, green middle, red low on the bus.
// R17: 8-bit luma/chroma sends Cb, Y, Cr, Y, one per clock.
// R18: RGB components span 0 to 255 or 16 to 235 as configured; the limited scaling here reaches only 16 to 234.
// R19: Line and field sync are active low on either side.
module vot_timing_unit
  import vot_pkg::*;
(
  input  logic        i_sys_clk,
  input  logic        i_rst_n,
  input  vot_cfg_t    i_cfg,
  input  vot_pix_t    i_pix,
  input  logic        i_pix_valid,
  output logic        o_pix_ready,
  input  logic        i_pixel_clock,
  output logic        o_pixel_clock,
  output logic        o_pixel_clock_oe,
  input  logic        i_hsync_n,
  output logic        o_hsync_n,
  output logic        o_hsync_oe,
  input  logic        i_vsync_n,
  output logic        o_vsync_n,
  output logic        o_vsync_oe,
  output logic [23:0] o_pixel_bus,
  output logic        o_active,
  output logic        o_underrun
);

  typedef enum logic {LN_BLANK, LN_ACTIVE} vot_line_t;

  typedef struct packed {
    logic [1:0]  phase;
    logic        pclk;
    logic        pclk_prev;
    logic        hs_prev;
    logic        vs_prev;
    logic [10:0] h;
    logic [9:0]  v;
    logic [9:0]  px;
    logic        hs_n;
    logic        vs_n;
    logic        vpin;
    vot_pix_t    prev;
    vot_pix_t    cur;
    logic [23:0] bus;
    vot_line_t   lstate;
    logic        underrun;
  } vot_state_t;

  vot_state_t  s;
  vot_state_t  nxt_s;
  logic [2:0]  sy;
  vot_pix_t    head;
  logic        head_valid;
  logic        tick;
  logic        line_start;
  logic        frame_start;
  logic        act;
  logic        slot;
  logic        pop;
  logic [10:0] htot;
  logic [9:0]  vtot;
  logic [9:0]  vact;
  logic [9:0]  vstart;
  logic [11:0] hspan;
  vot_pix_t    emit;
  vot_pix_t    black;

  // ==========================================================================
  // Pin synchroniser and pixel FIFO
  // ==========================================================================
  // R8 async clock in
  vot_sync #(
    .W (3)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_d       ({i_vsync_n, i_hsync_n, i_pixel_clock}),
    .o_q       (sy)
  );

  // R13 R14 no host or memory port: pixels leave only on the pixel bus
  vot_fifo #(
    .W (PIX_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_wr_data  (i_pix),
    .i_wr_valid (i_pix_valid),
    .o_wr_ready (o_pix_ready),
    .o_rd_data  (head),
    .o_rd_valid (head_valid),
    .i_rd_ready (pop)
  );

  // ==========================================================================
  // Bus formatting
  // ==========================================================================
  function automatic logic [23:0] fmt_bus(input vot_pix_t p, input vot_cfg_t c, input logic odd, input logic vodd);
    vot_pix_t   q;
    logic [2:0] th;
    q  = p;
    // R18 output range
    if (c.limited) begin
      q = '{hi: vot_scale(p.hi), mid: vot_scale(p.mid), lo: vot_scale(p.lo)};
    end
    // 2x2 ordered dither thresholds
    case ({vodd, odd})
      2'h0:    th = 3'h0;
      2'h1:    th = 3'h4;
      2'h2:    th = 3'h6;
      default: th = 3'h2;
    endcase
    // R9 format select
    case (c.fmt)
      // R16 blue high, red low
      FMT_RGB24: fmt_bus = q;
      // R10 dither to 5 bits
      FMT_RGB15: fmt_bus = {9'h000, vot_dither(q.hi, th), vot_dither(q.mid, th), vot_dither(q.lo, th)};
      FMT_YC16:  fmt_bus = {8'h00, p.lo, odd ? p.hi : p.mid};
      // R17 chroma first, Y follows
      FMT_YC8:   fmt_bus = {8'h00, odd ? p.hi : p.mid, 8'h00};
      default:   fmt_bus = '0;
    endcase
  endfunction : fmt_bus

  // ==========================================================================
  // Timing and data path
  // ==========================================================================
  always_comb begin
    nxt_s  = s;
    pop    = 1'b0;
    emit   = s.cur;
    htot   = i_cfg.pal ? H_TOTAL_PAL : H_TOTAL_NTSC;
    // R15 line count per standard
    vtot   = i_cfg.pal ? V_TOTAL_PAL : V_TOTAL_NTSC;
    vact   = i_cfg.pal ? V_ACT_PAL : V_ACT_NTSC;
    vstart = i_cfg.pal ? V_START_PAL : V_START_NTSC;
    black  = (i_cfg.fmt == FMT_YC16 || i_cfg.fmt == FMT_YC8) ? vot_pix_t'{hi: BLACK_C, mid: BLACK_C, lo: BLACK_Y} : '0;
    // R12 width from window and interpolation
    hspan  = {1'b0, i_cfg.window ? W_WINDOW : W_SOURCE, 1'b0} << i_cfg.hinterp;

    // R6 two ticks per three core clocks
    tick = i_cfg.clk_out ? (s.phase != PHASE_LAST) : (sy[SY_PCLK] & ~s.pclk_prev);
    nxt_s.pclk_prev = sy[SY_PCLK];
    nxt_s.phase     = (s.phase == PHASE_LAST) ? 2'h0 : s.phase + 2'h1;
    nxt_s.pclk      = i_cfg.clk_out & (nxt_s.phase != PHASE_LAST);

    // R7 syncs from the far side
    if (i_cfg.sync_out) begin
      line_start  = tick & (s.h == htot - 11'h001);
      frame_start = line_start & (s.v == vtot - 10'h001);
    end else begin
      line_start  = tick & ~sy[SY_HS] & s.hs_prev;
      frame_start = tick & ~sy[SY_VS] & s.vs_prev;
    end
    if (tick) begin
      nxt_s.hs_prev = sy[SY_HS];
      nxt_s.vs_prev = sy[SY_VS];
    end
    if (line_start) begin
      nxt_s.h = 11'h000;
    end else if (tick && s.h != H_MAX) begin
      nxt_s.h = s.h + 11'h001;
    end
    if (frame_start) begin
      nxt_s.v        = 10'h000;
      nxt_s.underrun = 1'b0;
    end else if (line_start && s.v != V_MAX) begin
      nxt_s.v = s.v + 10'h001;
    end

    // R19 low-active syncs
    nxt_s.hs_n = ~(nxt_s.h < HS_WIDTH);
    nxt_s.vs_n = ~(nxt_s.v < VS_LINES);
    // R5 composite sync on field pin
    nxt_s.vpin = i_cfg.csync_en ? (nxt_s.vs_n ? nxt_s.hs_n : ~nxt_s.hs_n) : nxt_s.vs_n;

    act  = ({1'b0, nxt_s.h} >= {1'b0, H_START}) && ({1'b0, nxt_s.h} < {1'b0, H_START} + hspan)
           && (nxt_s.v >= vstart) && (nxt_s.v < vstart + vact);
    // R1 change on sync fall, then every second clock; every clock in 8-bit luma/chroma
    slot = tick & (~nxt_s.h[0] | (i_cfg.fmt == FMT_YC8));

    if (slot) begin
      if (act && !nxt_s.h[0]) begin
        nxt_s.px = s.px + 10'h001;
        // R11 interpolate by two only
        if (!i_cfg.hinterp || !s.px[0]) begin
          pop = head_valid;
          if (head_valid) begin
            emit       = i_cfg.hinterp ? vot_pix_t'{hi: vot_avg(s.prev.hi, head.hi),
                                                    mid: vot_avg(s.prev.mid, head.mid),
                                                    lo: vot_avg(s.prev.lo, head.lo)} : head;
            nxt_s.prev = head;
          end else begin
            emit           = black;
            nxt_s.underrun = 1'b1;
          end
        end else begin
          emit = s.prev;
        end
        nxt_s.cur = emit;
        nxt_s.bus = fmt_bus(emit, i_cfg, s.px[0], s.v[0]);
      end else if (act) begin
        // R17 luma in second clock
        nxt_s.bus = {8'h00, s.cur.lo, 8'h00};
      end else begin
        nxt_s.px  = 10'h000;
        nxt_s.cur = black;
        nxt_s.bus = fmt_bus(black, i_cfg, 1'b0, 1'b0);
      end
    end
    nxt_s.lstate = act ? LN_ACTIVE : LN_BLANK;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s      <= '0;
      s.hs_n <= 1'b1;
      s.vs_n <= 1'b1;
      s.vpin <= 1'b1;
      // Start on the last NTSC pixel so the first sync fall is a true line start
      s.h         <= H_TOTAL_NTSC - 11'h001;
      // Edge detectors idle at the synchroniser's reset level
      s.pclk_prev <= 1'b1;
      s.hs_prev   <= 1'b1;
      s.vs_prev   <= 1'b1;
    end else begin
      s <= nxt_s;
    end
  end

  // ==========================================================================
  // Pins
  // ==========================================================================
  // R3 independent directions
  assign o_pixel_clock_oe = i_cfg.clk_out;
  // R4 one direction for both syncs
  assign o_hsync_oe       = i_cfg.sync_out;
  assign o_vsync_oe       = i_cfg.sync_out;
  assign o_pixel_clock    = s.pclk;
  assign o_hsync_n        = s.hs_n;
  assign o_vsync_n        = s.vpin;
  assign o_pixel_bus      = s.bus;
  assign o_active         = (s.lstate == LN_ACTIVE);
  assign o_underrun       = s.underrun;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_clk_div_pattern: assert property ( // R6
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cfg.clk_out && !tick |=> tick ##1 tick ##1 !tick)
    else $error("pixel clock tick pattern not two in three");

  a_bus_change_slot: assert property ( // R1
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cfg.fmt != FMT_YC8 && $changed(o_pixel_bus) |-> $past(slot) && !s.h[0])
    else $error("pixel bus changed outside a data slot");

  a_sync_dir_pair: assert property ( // R4
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_hsync_oe == o_vsync_oe && o_hsync_oe == i_cfg.sync_out && o_pixel_clock_oe == i_cfg.clk_out)
    else $error("sync or clock direction mismatch");

  a_csync_on_field: assert property ( // R5
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cfg.csync_en && !nxt_s.vs_n |=> o_vsync_n == !o_hsync_n)
    else $error("composite sync not on field pin");

  a_line_fall_start: assert property ( // R19
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cfg.sync_out && $fell(o_hsync_n) |-> s.h == 11'h000 && $past(tick))
    else $error("line sync fell away from line start");

  a_rgb24_order: assert property ( // R16
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cfg.fmt == FMT_RGB24 && !i_cfg.limited && !i_cfg.hinterp && pop |=> o_pixel_bus == $past(head))
    else $error("24-bit RGB byte order wrong");

  a_rgb15_top_zero: assert property ( // R10
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cfg.fmt == FMT_RGB15 && slot |=> o_pixel_bus[23:15] == 9'h000)
    else $error("15-bit RGB leaks into upper bits");

  a_yc8_luma_follow: assert property ( // R17
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cfg.fmt == FMT_YC8 && slot && act && nxt_s.h[0] |=> o_pixel_bus[15:8] == $past(s.cur.lo))
    else $error("8-bit luma not after chroma");

  a_range_limited: assert property ( // R18
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cfg.fmt == FMT_RGB24 && i_cfg.limited && slot |=>
      o_pixel_bus[23:16] >= RANGE_LO && o_pixel_bus[23:16] <= RANGE_HI && o_pixel_bus[7:0] <= RANGE_HI)
    else $error("limited range exceeded");

endmodule : vot_timing_unit
